// >>> adcid_regs.sv
// identification and status register pair with monitor flag capture
// Function
// RL1 - upper id bits read-only reserved content
// RL2 - low id bits hold read-only model code
// RL3 - power-on flag reads one after reset
// RL4 - power-on flag cleared only by zero write
// RL5 - bit 6 shows not ready, zero when ready
// RL6 - bit 5: positive output near high rail
// RL7 - bit 4: positive output near low rail
// RL8 - bit 3: negative output near high rail
// RL9 - bit 2: negative output near low rail
// RL10 - bit 1: reference below third of supply
// RL11 - bit 0: reference below low level
// RL12 - rail flags gated by rail monitor enable
// RL13 - reference flags gated by two-bit enable
// RL14 - status at 01h, resets to 80h; the code reads C0h until startup ends, with not-ready bit 6 set
// RL15 - access via read/write commands; reset restores defaults
// RL16 - identification register at address 00h
// RL17 - rail/ref flags follow synced monitors, writes ignored
module adcid_regs
  import adcid_pkg::*;
#(
  parameter logic [ADCID_MODEL_W-1:0] MODEL_CODE = 3'h1, // arbitrary value
  parameter logic [ADCID_RSVD_W-1:0] RSVD_BITS = 5'h00, // arbitrary value
  parameter int STARTUP_CYCLES = ADCID_STARTUP_CYCLES
) (
  input wire logic sys_clk, // device clock, 50 MHz
  input wire logic resetn, // async reset, active low
  input wire logic [7:0] reg_addr, // register address from command decoder
  input wire logic reg_rd, // register_read_cmd strobe
  input wire logic reg_wr, // register_write_cmd strobe
  input wire logic [7:0] reg_wdata, // write data byte
  output logic [7:0] reg_rdata, // read data byte
  output logic reg_rvalid, // read data valid pulse
  input wire logic rail_monitor_enable, // rail monitor enable from 06h
  input wire logic [1:0] ref_monitor_enable, // reference monitor enables from 05h
  input wire logic mon_pos_hi, // comparator: positive output near high rail
  input wire logic mon_pos_lo, // comparator: positive output near low rail
  input wire logic mon_neg_hi, // comparator: negative output near high rail
  input wire logic mon_neg_lo, // comparator: negative output near low rail
  input wire logic mon_ref_l1, // comparator: reference below third supply
  input wire logic mon_ref_l0, // comparator: reference below low level
  output logic device_ready // startup finished
);
  localparam int CW = $clog2(STARTUP_CYCLES + 1);
  localparam logic [CW-1:0] CNT_END = CW'(STARTUP_CYCLES);

  logic [5:0] mon_sync;
  logic power_on_flag_q;
  logic pos_out_near_high_rail, pos_out_near_low_rail;
  logic neg_out_near_high_rail, neg_out_near_low_rail;
  logic ref_below_third_supply, ref_below_low_level;
  logic [CW-1:0] start_cnt_q;
  adcid_state_t state_q;
  logic [7:0] device_status, device_identification;

  adcid_sync #(.W(6)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in({mon_pos_hi, mon_pos_lo, mon_neg_hi, mon_neg_lo, mon_ref_l1, mon_ref_l0}),
    .sync_out(mon_sync)
  );

  // flags follow the synchronised monitors, no latching
  assign pos_out_near_high_rail = rail_monitor_enable & mon_sync[ADCID_BIT_P_HI]; // RL6 RL12 RL17
  assign pos_out_near_low_rail = rail_monitor_enable & mon_sync[ADCID_BIT_P_LO]; // RL7 RL12
  assign neg_out_near_high_rail = rail_monitor_enable & mon_sync[ADCID_BIT_N_HI]; // RL8 RL12
  assign neg_out_near_low_rail = rail_monitor_enable & mon_sync[ADCID_BIT_N_LO]; // RL9 RL12
  assign ref_below_third_supply = ref_monitor_enable[1] & mon_sync[ADCID_BIT_REF_L1]; // RL10 RL13
  assign ref_below_low_level = ref_monitor_enable[0] & mon_sync[ADCID_BIT_REF_L0]; // RL11 RL13

  // startup sequencing for the not-ready bit
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ADCID_ST_START;
      start_cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ADCID_ST_START:
        begin
          if (start_cnt_q == CNT_END)
            state_q <= ADCID_ST_READY;
          else
            start_cnt_q <= start_cnt_q + CW'(1);
        end
        ADCID_ST_READY:
          state_q <= ADCID_ST_READY;
        default:
          state_q <= ADCID_ST_START;
      endcase
    end
  end
  assign device_ready = (state_q == ADCID_ST_READY); // RL5

  // power-on flag: set by reset, cleared only by a zero write
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      power_on_flag_q <= ADCID_STATUS_RESET[ADCID_BIT_POR]; // RL3 RL14 RL15
    else if (reg_wr && reg_addr == ADCID_ADDR_STATUS && !reg_wdata[ADCID_BIT_POR])
      power_on_flag_q <= 1'b0; // RL4 RL17
  end

  always_comb
  begin
    device_status = '0;
    device_status[ADCID_BIT_POR] = power_on_flag_q;
    device_status[ADCID_BIT_NRDY] = ~device_ready; // RL5
    device_status[ADCID_BIT_P_HI] = pos_out_near_high_rail;
    device_status[ADCID_BIT_P_LO] = pos_out_near_low_rail;
    device_status[ADCID_BIT_N_HI] = neg_out_near_high_rail;
    device_status[ADCID_BIT_N_LO] = neg_out_near_low_rail;
    device_status[ADCID_BIT_REF_L1] = ref_below_third_supply;
    device_status[ADCID_BIT_REF_L0] = ref_below_low_level;
  end
  assign device_identification = {RSVD_BITS, MODEL_CODE}; // RL1 RL2

  // read data registered one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        if (reg_addr == ADCID_ADDR_ID)
          reg_rdata <= device_identification; // RL16
        else if (reg_addr == ADCID_ADDR_STATUS)
          reg_rdata <= device_status; // RL14
        else
          reg_rdata <= '0;
      end
    end
  end

  // edges since reset release, saturating; read only by the startup check
  localparam int SW = CW + 1;
  logic [SW-1:0] since_rst_q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      since_rst_q <= '0;
    else if (!since_rst_q[SW-1])
      since_rst_q <= since_rst_q + SW'(1);
  end

  // power-on flag
  chk_por_clear_only: assert property (@(posedge sys_clk) disable iff (!resetn) // RL4
    $fell(power_on_flag_q) |-> $past(reg_wr) && $past(reg_addr) == ADCID_ADDR_STATUS)
    else $error("power-on flag cleared without write");
  chk_por_write_clear: assert property (@(posedge sys_clk) disable iff (!resetn) // RL4
    reg_wr && reg_addr == ADCID_ADDR_STATUS && !reg_wdata[ADCID_BIT_POR] |=> !power_on_flag_q)
    else $error("zero write did not clear power-on flag");
  chk_por_write_keep: assert property (@(posedge sys_clk) disable iff (!resetn) // RL4
    power_on_flag_q && !(reg_wr && reg_addr == ADCID_ADDR_STATUS && !reg_wdata[ADCID_BIT_POR])
      |=> power_on_flag_q)
    else $error("power-on flag lost without zero write");
  chk_por_after_reset: assert property (@(posedge sys_clk) // RL3
    $rose(resetn) |-> power_on_flag_q)
    else $error("power-on flag not set after reset");

  // startup and readiness
  chk_ready_time: assert property (@(posedge sys_clk) // RL5
    $rose(resetn) |-> ##[1:300] device_ready)
    else $error("device never became ready");
  chk_ready_count: assert property (@(posedge sys_clk) disable iff (!resetn) // RL5
    device_ready == (since_rst_q > SW'(STARTUP_CYCLES)))
    else $error("ready bit off its startup count");
  chk_ready_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // RL5
    device_ready |=> device_ready)
    else $error("ready bit dropped without reset");

  // register access
  chk_rvalid_pulse: assert property (@(posedge sys_clk) disable iff (!resetn) // RL15
    reg_rvalid == $past(reg_rd))
    else $error("read valid not one cycle after strobe");
  chk_rdata_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // RL15
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_id_read: assert property (@(posedge sys_clk) disable iff (!resetn) // RL1 RL2
    reg_rd && reg_addr == ADCID_ADDR_ID |=> reg_rvalid && reg_rdata == {RSVD_BITS, MODEL_CODE})
    else $error("id read returned wrong content");
  chk_status_read: assert property (@(posedge sys_clk) disable iff (!resetn) // RL14
    reg_rd && reg_addr == ADCID_ADDR_STATUS
      |=> reg_rdata[ADCID_BIT_POR] == $past(power_on_flag_q))
    else $error("status read lost power-on flag");
  chk_unmapped_read: assert property (@(posedge sys_clk) disable iff (!resetn) // RL16
    reg_rd && reg_addr != ADCID_ADDR_ID && reg_addr != ADCID_ADDR_STATUS
      |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");

  // monitor flags, two cycles behind the comparators
  chk_rail_gated: assert property (@(posedge sys_clk) disable iff (!resetn) // RL12
    !rail_monitor_enable |-> device_status[ADCID_BIT_P_HI:ADCID_BIT_N_LO] == 4'h0)
    else $error("rail flag set while monitor off");
  chk_ref_gated: assert property (@(posedge sys_clk) disable iff (!resetn) // RL13
    (ref_monitor_enable == 2'h0) |-> device_status[ADCID_BIT_REF_L1:ADCID_BIT_REF_L0] == 2'h0)
    else $error("reference flag set while monitor off");
  chk_rail_follow: assert property (@(posedge sys_clk) disable iff (!resetn) // RL6
    resetn && mon_pos_hi |-> ##2 (pos_out_near_high_rail == rail_monitor_enable))
    else $error("rail flag did not follow monitor");
  chk_rail_clear: assert property (@(posedge sys_clk) disable iff (!resetn) // RL6
    resetn && !mon_pos_hi |-> ##2 !pos_out_near_high_rail)
    else $error("rail flag set without monitor");
  chk_pos_low_follow: assert property (@(posedge sys_clk) disable iff (!resetn) // RL7
    resetn && mon_pos_lo |-> ##2 (pos_out_near_low_rail == rail_monitor_enable))
    else $error("low rail flag did not follow monitor");
  chk_neg_high_follow: assert property (@(posedge sys_clk) disable iff (!resetn) // RL8
    resetn && mon_neg_hi |-> ##2 (neg_out_near_high_rail == rail_monitor_enable))
    else $error("negative high rail flag did not follow monitor");
  chk_neg_low_follow: assert property (@(posedge sys_clk) disable iff (!resetn) // RL9
    resetn && mon_neg_lo |-> ##2 (neg_out_near_low_rail == rail_monitor_enable))
    else $error("negative low rail flag did not follow monitor");
  chk_ref_follow: assert property (@(posedge sys_clk) disable iff (!resetn) // RL11
    resetn && mon_ref_l0 |-> ##2 (ref_below_low_level == ref_monitor_enable[0]))
    else $error("reference flag did not follow monitor");
  chk_ref_clear: assert property (@(posedge sys_clk) disable iff (!resetn) // RL11
    resetn && !mon_ref_l0 |-> ##2 !ref_below_low_level)
    else $error("reference flag set without monitor");
  chk_ref_third_follow: assert property (@(posedge sys_clk) disable iff (!resetn) // RL10
    resetn && mon_ref_l1 |-> ##2 (ref_below_third_supply == ref_monitor_enable[1]))
    else $error("third-supply flag did not follow monitor");
  chk_ref_third_clear: assert property (@(posedge sys_clk) disable iff (!resetn) // RL10
    resetn && !mon_ref_l1 |-> ##2 !ref_below_third_supply)
    else $error("third-supply flag set without monitor");
endmodule // adcid_regs

// >>> adcid_pkg.sv
// package: register map, field positions and reset values of the id/status pair
package adcid_pkg;
  localparam logic [7:0] ADCID_ADDR_ID = 8'h00;
  localparam logic [7:0] ADCID_ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADCID_STATUS_RESET = 8'h80;
  localparam int ADCID_BIT_POR = 7;
  localparam int ADCID_BIT_NRDY = 6;
  localparam int ADCID_BIT_P_HI = 5;
  localparam int ADCID_BIT_P_LO = 4;
  localparam int ADCID_BIT_N_HI = 3;
  localparam int ADCID_BIT_N_LO = 2;
  localparam int ADCID_BIT_REF_L1 = 1;
  localparam int ADCID_BIT_REF_L0 = 0;
  localparam int ADCID_MODEL_W = 3;
  localparam int ADCID_RSVD_W = 5;
  localparam int ADCID_REFEN_W = 2;
  // startup count until ready, in device clocks
  localparam int ADCID_STARTUP_CYCLES = 16;
  typedef enum logic [1:0] {
    ADCID_ST_START = 2'b00,
    ADCID_ST_READY = 2'b01
  } adcid_state_t;
endpackage

// >>> adcid_sync.sv
// two-flop level synchroniser for the monitor comparator outputs
module adcid_sync #(
  parameter int W = 6
) (
  input wire logic sys_clk, // device clock
  input wire logic resetn, // async reset, active low
  input wire logic [W-1:0] async_in, // raw comparator levels
  output logic [W-1:0] sync_out // synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // adcid_sync

// >>> adcid_host.sv
// host model: single-byte register read and write commands
module adcid_host (
  input wire logic sys_clk, // device clock
  output logic [7:0] reg_addr = 8'h00, // register address
  output logic reg_rd = 1'b0, // read strobe
  output logic reg_wr = 1'b0, // write strobe
  output logic [7:0] reg_wdata = 8'h00, // write data
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid // read data valid
);
  timeunit 1ns;
  timeprecision 1ps;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      #1;
      if (reg_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = reg_rdata;
      end
      else
        @(posedge sys_clk);
    end
  endtask
endmodule // adcid_host

// >>> testbench.sv
// testbench: register reads and writes against the id/status pair
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic rail_en = 1'b0;
  logic [1:0] ref_en = 2'h0;
  logic [5:0] mon = 6'h00;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_rd, reg_wr, reg_rvalid, device_ready, ok;
  int failures = 0;
  int cmp_count = 0;
  always #10 sys_clk = ~sys_clk;
  adcid_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // model code and reserved bits are arbitrary neutral values
  adcid_regs #(.MODEL_CODE(3'h2), .RSVD_BITS(5'h15), .STARTUP_CYCLES(2)) dut (
    .sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rail_monitor_enable(rail_en),
    .ref_monitor_enable(ref_en), .mon_pos_hi(mon[5]), .mon_pos_lo(mon[4]), .mon_neg_hi(mon[3]),
    .mon_neg_lo(mon[2]), .mon_ref_l1(mon[1]), .mon_ref_l0(mon[0]), .device_ready(device_ready));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv, ok);
    if (ok !== 1'b1)
    begin
      failures++;
      complete_run();
    end
    else
      check(rv, exp);
  endtask
  task wait_ready;
    for (int i = 0; i < 40 && device_ready !== 1'b1; i++)
      @(negedge sys_clk);
    if (device_ready !== 1'b1)
    begin
      failures++;
      complete_run();
    end
  endtask
  task apply(input logic [5:0] m, input logic r, input logic [1:0] f);
    @(posedge sys_clk);
    mon <= m;
    rail_en <= r;
    ref_en <= f;
    repeat (3) @(posedge sys_clk);
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_chk(8'h01, 8'hc0);
    wait_ready();
    rd_chk(8'h01, 8'h80);
    rd_chk(8'h00, 8'haa);
    $display("test reset values done");
    host.wr(8'h01, 8'hff);
    rd_chk(8'h01, 8'h80);
    host.wr(8'h00, 8'hff);
    rd_chk(8'h00, 8'haa);
    host.wr(8'h01, 8'h00);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h05, 8'h00);
    $display("test writes done");
    apply(6'h3f, 1'b0, 2'h0);
    rd_chk(8'h01, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      apply(6'h3f, 1'b1, i[1:0]);
      rd_chk(8'h01, 8'h3c | {6'h00, i[1:0]});
    end
    for (int i = 0; i < 6; i++)
    begin
      apply(6'h01 << i, 1'b1, 2'h3);
      rd_chk(8'h01, 8'h01 << i);
    end
    apply(6'h00, 1'b1, 2'h3);
    host.wr(8'h01, 8'h3f);
    rd_chk(8'h01, 8'h00);
    $display("test monitor flags done");
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    wait_ready();
    rd_chk(8'h01, 8'h80);
    $display("test second reset done");
    complete_run();
  end
endmodule // testbench
